// [phy_train_pkg.sv]
// shared types, register map and timing constants for the training control block
package phy_train_pkg;

	localparam int unsigned CLK_PERIOD_PS    = 4000;
	localparam int unsigned IDLE_HOLD_MIN_NS = 3240;
	localparam int unsigned IDLE_HOLD_MAX_NS = 1000000;
	localparam int unsigned IDLE_HOLD_CYC    = (IDLE_HOLD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned IDLE_HOLD_MAXCYC = (IDLE_HOLD_MAX_NS / CLK_PERIOD_PS) * 1000;
	localparam int unsigned MINWAIT_US_DEF   = 10;
	localparam int unsigned REM_AGREE_CNT    = 8;

	localparam int unsigned WAIT_W = 32;
	localparam int unsigned HOLD_W = 12;
	localparam int unsigned AGR_W  = 4;

	localparam logic [11:0] ADDR_CTRL   = 12'h0_000;
	localparam logic [11:0] ADDR_STATUS = 12'h0_004;

	localparam int unsigned CTRL_LEADER_BIT  = 0;
	localparam int unsigned CTRL_RESTART_BIT = 1;
	localparam logic        CTRL_LEADER_RST  = 1'b0;

	localparam int unsigned ST_STATE_LSB  = 0;
	localparam int unsigned ST_REMOK_BIT  = 4;
	localparam int unsigned ST_LOCOK_BIT  = 5;
	localparam int unsigned ST_TDONE_BIT  = 6;
	localparam int unsigned ST_LEADER_BIT = 7;

	typedef enum logic [1:0] {SEND_I, SEND_N, SEND_Z} txMode_t;

	typedef enum {ST_TRAIN, ST_IDLE, ST_DATA, ST_HOLD, ST_QUIET} ctlState_t;

	typedef struct packed {
		txMode_t mode;
		logic    locOk;
		logic    frameEn;
	} txCtrl_t;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apbReq_t;

	function automatic logic [2:0] stateCode(input ctlState_t s);
		unique case (s)
			ST_TRAIN: stateCode = 3'h0;
			ST_IDLE:  stateCode = 3'h1;
			ST_DATA:  stateCode = 3'h2;
			ST_HOLD:  stateCode = 3'h3;
			ST_QUIET: stateCode = 3'h4;
		endcase
	endfunction : stateCode

endpackage : phy_train_pkg

// [rem_status_tracker.sv]
// remote receiver status recovered from the partner's scrambler indication
`timescale 1ns/1ps
module rem_status_tracker
	import phy_train_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic symValid,
	input  wire logic remBit,
	input  wire logic clear,
	output logic      remOk_q
);
	logic [AGR_W-1:0] agree_q;
	logic [AGR_W-1:0] agree_d;
	logic             remOk_d;

	// one stray symbol must not flip the status: wait for a run of agreeing ones
	always_comb begin
		agree_d = agree_q;
		remOk_d = remOk_q;
		if (clear) begin
			agree_d = '0;
			remOk_d = 1'b0;
		end else if (symValid) begin
			if (remBit == remOk_q) begin
				agree_d = '0;
			end else if (agree_q == AGR_W'(REM_AGREE_CNT - 1)) begin
				agree_d = '0;
				remOk_d = remBit;
			end else begin
				agree_d = agree_q + AGR_W'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			agree_q <= '0;
			remOk_q <= 1'b0;
		end else begin
			agree_q <= agree_d;
			remOk_q <= remOk_d;
		end
	end
endmodule : rem_status_tracker

// [phy_train_ctl.sv]
// training-phase control state machine with APB registers
`timescale 1ns/1ps
module phy_train_ctl
	import phy_train_pkg::*;
#(
	parameter int unsigned MINWAIT_US = MINWAIT_US_DEF
)(
	input  wire logic  mclk,
	input  wire logic  rst_n,
	input  wire logic  psel,
	input  wire logic  penable,
	input  wire logic  pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	input  wire logic  locRcvrOk,
	input  wire logic  rxSymValid,
	input  wire logic  rxRemBit,
	input  wire logic  rxInvalid,
	output txCtrl_t    txCtrl_q,
	output logic       linkUp_q
);
	localparam int unsigned MINWAIT_CYC = (MINWAIT_US * 1000000) / CLK_PERIOD_PS;
	localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(MINWAIT_CYC - 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(IDLE_HOLD_CYC - 1);

	apbReq_t    req;
	ctlState_t  stQ;
	ctlState_t  stD;
	logic [WAIT_W-1:0] waitCnt_q;
	logic [WAIT_W-1:0] waitCnt_d;
	logic [HOLD_W-1:0] holdCnt_q;
	logic [HOLD_W-1:0] holdCnt_d;
	logic       leader_q;
	logic       leader_d;
	logic       remOk;
	logic       timerDone;
	logic       mgmtRestart;
	logic       restartReq;
	logic       wrTake;
	logic       rdTake;
	logic       addrOk;
	txCtrl_t    txCtrl_d;
	logic       linkUp_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic       pready_q;
	logic       pready_d;
	logic       pslverr_q;
	logic       pslverr_d;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// ---------------- APB slave: one wait state, pready from a flop
	assign addrOk = (req.paddr == ADDR_CTRL) || (req.paddr == ADDR_STATUS);
	assign wrTake = req.psel && req.penable && pready_q && req.pwrite;
	assign rdTake = req.psel && req.penable && !pready_q && !req.pwrite;
	// restart is a self-clearing command bit, only its byte lane counts
	assign mgmtRestart = wrTake && (req.paddr == ADDR_CTRL) && pstrb[0] && req.pwdata[CTRL_RESTART_BIT];

	always_comb begin
		pready_d  = req.psel && req.penable && !pready_q;
		pslverr_d = req.psel && req.penable && !pready_q && !addrOk;
		prdata_d  = prdata_q;
		leader_d  = leader_q;
		if (rdTake) begin
			prdata_d = '0;
			if (req.paddr == ADDR_CTRL) begin
				prdata_d[CTRL_LEADER_BIT] = leader_q;
			end else if (req.paddr == ADDR_STATUS) begin
				prdata_d[ST_STATE_LSB +: 3] = stateCode(stQ);
				prdata_d[ST_REMOK_BIT]      = remOk;
				prdata_d[ST_LOCOK_BIT]      = locRcvrOk;
				prdata_d[ST_TDONE_BIT]      = timerDone;
				prdata_d[ST_LEADER_BIT]     = leader_q;
			end
		end
		if (wrTake && (req.paddr == ADDR_CTRL) && pstrb[0]) begin
			leader_d = req.pwdata[CTRL_LEADER_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
			leader_q  <= CTRL_LEADER_RST;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
			leader_q  <= leader_d;
		end
	end

	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign prdata  = prdata_q;

	// ---------------- remote receiver status from the partner's scrambler
	rem_status_tracker u_rem (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.symValid (rxSymValid),
		.remBit   (rxRemBit),
		.clear    (restartReq),
		.remOk_q  (remOk)
	);

	// ---------------- control state machine
	// invalid codes count in every state except training; in training they are expected noise
	assign restartReq = mgmtRestart || (rxInvalid && (stQ != ST_TRAIN));
	assign timerDone  = (waitCnt_q == WAIT_LAST);

	// role is reported only: the transitions below never look at it
	always_comb begin
		stD       = stQ;
		waitCnt_d = waitCnt_q;
		holdCnt_d = holdCnt_q;
		if (restartReq) begin
			stD       = ST_TRAIN;
			waitCnt_d = '0;
			holdCnt_d = '0;
		end else begin
			unique case (stQ)
				ST_TRAIN: begin
					if (!timerDone) begin
						waitCnt_d = waitCnt_q + WAIT_W'(1);
					end
					// a silent partner leaves locRcvrOk low, so we stay here
					if (locRcvrOk && timerDone) begin
						stD = remOk ? ST_DATA : ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (!locRcvrOk) begin
						stD       = ST_HOLD;
						holdCnt_d = '0;
					end else if (remOk) begin
						stD = ST_DATA;
					end
				end
				ST_DATA: begin
					stD = ST_DATA;
				end
				ST_HOLD: begin
					// minimum hold, far inside the 1 ms ceiling
					if (holdCnt_q == HOLD_LAST) begin
						stD = ST_QUIET;
					end else begin
						holdCnt_d = holdCnt_q + HOLD_W'(1);
					end
				end
				ST_QUIET: begin
					if (locRcvrOk) begin
						stD       = ST_TRAIN;
						waitCnt_d = '0;
					end
				end
			endcase
		end
	end

	// outputs follow the next state so they change with the state flop
	always_comb begin
		txCtrl_d = '{mode: SEND_I, locOk: 1'b0, frameEn: 1'b0};
		linkUp_d = 1'b0;
		unique case (stD)
			ST_TRAIN: txCtrl_d = '{mode: SEND_I, locOk: 1'b0, frameEn: 1'b0};
			ST_IDLE: begin
				txCtrl_d = '{mode: SEND_I, locOk: 1'b1, frameEn: 1'b0};
				linkUp_d = 1'b1;
			end
			ST_DATA: begin
				txCtrl_d = '{mode: SEND_N, locOk: 1'b1, frameEn: 1'b1};
				linkUp_d = 1'b1;
			end
			ST_HOLD:  txCtrl_d = '{mode: SEND_I, locOk: 1'b1, frameEn: 1'b0};
			ST_QUIET: txCtrl_d = '{mode: SEND_Z, locOk: 1'b0, frameEn: 1'b0};
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stQ       <= ST_TRAIN;
			waitCnt_q <= '0;
			holdCnt_q <= '0;
			txCtrl_q  <= '{mode: SEND_I, locOk: 1'b0, frameEn: 1'b0};
			linkUp_q  <= 1'b0;
		end else begin
			stQ       <= stD;
			waitCnt_q <= waitCnt_d;
			holdCnt_q <= holdCnt_d;
			txCtrl_q  <= txCtrl_d;
			linkUp_q  <= linkUp_d;
		end
	end

	// ---------------- checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_train_hold: assert property ((stQ == ST_TRAIN) && !(locRcvrOk && timerDone) |=> stQ == ST_TRAIN)
		else $error("left training without ready receiver and expired timer");
	chk_to_idle: assert property ((stQ == ST_TRAIN) && locRcvrOk && timerDone && !remOk && !restartReq
			|=> (stQ == ST_IDLE) && txCtrl_q.locOk && (txCtrl_q.mode == SEND_I))
		else $error("training exit with partner not ready did not reach idle-only");
	chk_to_data: assert property ((stQ == ST_TRAIN) && locRcvrOk && timerDone && remOk && !restartReq
			|=> (stQ == ST_DATA) && linkUp_q)
		else $error("training exit with partner ready did not reach data state");
	chk_train_tx: assert property ((stQ == ST_TRAIN) |-> (txCtrl_q.mode == SEND_I) && !txCtrl_q.locOk && !linkUp_q)
		else $error("training must send idle codes signalling not ready");
	chk_data_tx: assert property ((stQ == ST_DATA) |-> (txCtrl_q.mode == SEND_N) && txCtrl_q.frameEn)
		else $error("data state must send normal codes");
	chk_idle_tx: assert property ((stQ == ST_IDLE) |-> (txCtrl_q.mode == SEND_I) && txCtrl_q.locOk && !txCtrl_q.frameEn)
		else $error("idle-only state must send idle codes signalling ready");
	chk_restart_train: assert property (restartReq |=> (stQ == ST_TRAIN) && (waitCnt_q == '0) && !remOk)
		else $error("restart did not return to training with timer cleared");
	chk_hold_time: assert property ((stQ == ST_HOLD) && (stD == ST_QUIET) |-> (holdCnt_q == HOLD_LAST))
		else $error("idle codes held for the wrong time before quiet");
	chk_wait_timer: assert property ($rose(stQ == ST_TRAIN) |-> (waitCnt_q == '0))
		else $error("training entered with a running timer");
	chk_apb_ready: assert property (psel && penable && !pready_q |=> pready_q)
		else $error("apb access not answered after one wait state");
endmodule : phy_train_ctl

// [peer_phy_model.sv]
// behavioural link partner that sends its receiver status toward the block
`timescale 1ns/1ps
module peer_phy_model (
	input  wire logic mclk,
	input  wire logic talk,
	input  wire logic remReady,
	input  wire logic badCodes,
	output logic      rxSymValid,
	output logic      rxRemBit,
	output logic      rxInvalid
);
	logic junkQ = 1'h0;
	// a silent line must not look like a steady status bit
	always @(posedge mclk) begin
		junkQ <= ~junkQ;
	end
	assign rxSymValid = talk;
	assign rxRemBit   = talk ? remReady : junkQ;
	assign rxInvalid  = badCodes;
endmodule : peer_phy_model

// [test_phy_train_ctl.sv]
// self-checking bench for the training control block
`timescale 1ns/1ps
module test_phy_train_ctl;
	import phy_train_pkg::*;
	logic        mclk, rst_n, psel, penable, pwrite, locRcvrOk;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb;
	logic        pready, pslverr, rerr, linkUp_q, talk, remReady, badCodes;
	logic        rxSymValid, rxRemBit, rxInvalid;
	txCtrl_t     txCtrl_q;
	int          errTotal, checksDone, cycles;

	phy_train_ctl #(.MINWAIT_US(1)) i_phy_train_ctl (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .locRcvrOk(locRcvrOk),
		.rxSymValid(rxSymValid), .rxRemBit(rxRemBit), .rxInvalid(rxInvalid),
		.txCtrl_q(txCtrl_q), .linkUp_q(linkUp_q));
	peer_phy_model i_peer_phy_model (.mclk(mclk), .talk(talk), .remReady(remReady),
		.badCodes(badCodes), .rxSymValid(rxSymValid), .rxRemBit(rxRemBit), .rxInvalid(rxInvalid));

	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end

	task automatic end_of_test();
		if (errTotal == 0 && checksDone > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			errTotal++;
			$display("MISMATCH %0t timeout", $time);
			end_of_test();
		end
	end

	task automatic cmpTx(input txMode_t m, input logic lo, input logic fe, input logic lk);
		txCtrl_t e;
		e = '{mode: m, locOk: lo, frameEn: fe};
		@(negedge mclk);
		checksDone++;
		if (txCtrl_q !== e || linkUp_q !== lk) begin
			errTotal++;
			$display("MISMATCH %0t tx %h link %b", $time, txCtrl_q, linkUp_q);
		end
	endtask : cmpTx

	task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH %0t reg %h exp %h", $time, got, exp);
		end
	endtask : cmpReg

	// pready is read at the rising edge itself: that edge completes the transfer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	initial begin
		{rst_n, psel, penable, pwrite, locRcvrOk, talk, remReady, badCodes} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h1;
		errTotal = 0;
		checksDone = 0;
		cycles = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		cmpTx(SEND_I, 1'h0, 1'h0, 1'h0);
		apb(1'h0, ADDR_STATUS, 32'h0000_0000);
		cmpReg(rdat, 32'h0000_0000);
		apb(1'h1, 12'h00C, 32'hFFFF_FFFF);
		cmpReg({31'h0000_0000, rerr}, 32'h0000_0001);
		apb(1'h0, 12'h008, 32'h0000_0000);
		cmpReg({rdat[30:0], rerr}, 32'h0000_0001);
		apb(1'h0, ADDR_CTRL, 32'h0000_0000);
		cmpReg(rdat, 32'h0000_0000);
		@(posedge mclk);
		talk <= 1'h1;
		repeat (300) @(posedge mclk);
		cmpTx(SEND_I, 1'h0, 1'h0, 1'h0);
		apb(1'h0, ADDR_STATUS, 32'h0000_0000);
		cmpReg(rdat, 32'h0000_0040);
		locRcvrOk <= 1'h1;
		repeat (2) @(posedge mclk);
		cmpTx(SEND_I, 1'h1, 1'h0, 1'h1);
		@(posedge mclk);
		remReady <= 1'h1;
		repeat (20) @(posedge mclk);
		cmpTx(SEND_N, 1'h1, 1'h1, 1'h1);
		@(posedge mclk);
		badCodes <= 1'h1;
		@(posedge mclk);
		badCodes <= 1'h0;
		cmpTx(SEND_I, 1'h0, 1'h0, 1'h0);
		repeat (200) @(posedge mclk);
		cmpTx(SEND_I, 1'h0, 1'h0, 1'h0);
		repeat (70) @(posedge mclk);
		cmpTx(SEND_N, 1'h1, 1'h1, 1'h1);
		apb(1'h1, ADDR_CTRL, 32'h0000_0003);
		@(posedge mclk);
		talk <= 1'h0;
		locRcvrOk <= 1'h0;
		remReady <= 1'h0;
		cmpTx(SEND_I, 1'h0, 1'h0, 1'h0);
		apb(1'h0, ADDR_CTRL, 32'h0000_0000);
		cmpReg(rdat, 32'h0000_0001);
		repeat (300) @(posedge mclk);
		cmpTx(SEND_I, 1'h0, 1'h0, 1'h0);
		@(posedge mclk);
		talk <= 1'h1;
		locRcvrOk <= 1'h1;
		repeat (2) @(posedge mclk);
		cmpTx(SEND_I, 1'h1, 1'h0, 1'h1);
		apb(1'h0, ADDR_STATUS, 32'h0000_0000);
		cmpReg(rdat & 32'hFFFF_FFBF, 32'h0000_00A1);
		@(posedge mclk);
		locRcvrOk <= 1'h0;
		repeat (805) @(posedge mclk);
		cmpTx(SEND_I, 1'h1, 1'h0, 1'h0);
		repeat (10) @(posedge mclk);
		cmpTx(SEND_Z, 1'h0, 1'h0, 1'h0);
		end_of_test();
	end
endmodule : test_phy_train_ctl
